//--- rtl/dct_top.sv
/*
  Connectivity test logic of a DRAM device: in test mode the command,
  address, clock and control pins are combined by fixed XOR terms onto the
  data and strobe pins, while clocked housekeeping tracks entry and exit.
  Assumes the reference clock runs while the device is powered and that
  the board agent keeps reset high and supplies stable before entry.
*/
// Summary of operation
// - Minterms 0 to 4 are fixed three-input XORs of address and control pins.
// - Minterms 5, 6, 8 and 9 are fixed XORs; minterm 9 uses reset AND enable.
// - Test outputs drive only while chip select is low, else high impedance.
// - x4: data bits 0 and 1 are XORs of minterm pairs 0/1 and 2/3.
// - x4: data bits 2 and 3 are XORs of minterm pairs 4/5 and 6/7.
// - x4: true strobe carries minterm 8, complementary strobe minterm 9.
// - x8: data bit n carries minterm n; strobes carry minterms 8 and 9.
// - x16: lower data bits carry minterms 0-7; lower strobes minterms 8 and 9.
// - x16: upper data bits and strobes are inversions of the lower ones.
// - Clock pair and CKE become test inputs within the clock input delay.
// - Other inputs become valid after the enable delay once chip select permits.
// - No array refresh, external or internal, happens during connectivity test.
// - After exit the array and states are unknown; full reset is required.
// - Outputs settle within the settle time while enabled and chip selected.
`timescale 1ns/10ps
module dct_top
  import dct_pkg::*;
(
  input wire logic ref_clk, // Reference clock, 10 MHz.
  input wire logic rst, // Synchronous reset, active high.
  input wire logic test_enable_pin, // Connectivity test enable, high active.
  input wire logic cs_n, // Chip select, low active.
  input wire logic [13:0] addr, // Address pins A0 to A13.
  input wire logic we_a14_n, // WE_n / A14.
  input wire logic cas_a15_n, // CAS_n / A15.
  input wire logic ras_a16_n, // RAS_n / A16.
  input wire logic [1:0] ba, // Bank address.
  input wire logic [1:0] bg, // Bank group.
  input wire logic act_n, // Activate, low active.
  input wire logic cke, // Clock enable.
  input wire logic odt, // On-die termination control.
  input wire logic ck_t, // True clock pin, a plain test input here.
  input wire logic ck_c, // Complementary clock pin, a plain test input here.
  input wire logic par, // Command parity.
  input wire logic alert_n, // Alert pin input side.
  input wire logic reset_n, // Device reset pin, low active.
  input wire logic dm_lower_n, // Lower data mask / inversion.
  input wire logic dm_upper_n, // Upper data mask / inversion.
  input wire logic [1:0] width_sel, // Part width strap.
  input wire logic refresh_req, // Auto or self refresh request from the core.
  output logic [15:0] dq_out, // Data pin output values.
  output logic [15:0] dq_oe, // Data pin output enables.
  output logic [3:0] dqs_out, // Strobes: lower t, lower c, upper t, upper c.
  output logic [3:0] dqs_oe, // Strobe output enables.
  output logic clk_inputs_valid, // Clock pair and CKE act as test inputs.
  output logic test_inputs_valid, // All test inputs valid.
  output logic outputs_settled, // Test outputs settled.
  output logic refresh_grant, // Refresh allowed to proceed.
  output logic vref_half_select, // Data reference forced to half supply.
  output logic reset_required // Mode was left; full reset needed.
);

  localparam int ENTRY_MAX = 12;

  dct_pins_if pins ();

  logic [2:0] te_sync;
  logic [2:0] cs_sync;
  logic te_stable;
  logic cs_low_stable;
  logic [2:0] next_te_sync;
  logic [2:0] next_cs_sync;
  logic next_te_stable;
  logic next_cs_low_stable;

  dct_state_type state;
  dct_state_type next_state;
  logic [7:0] cnt;
  logic [7:0] next_cnt;
  logic [7:0] settle_cnt;
  logic [7:0] next_settle_cnt;
  logic next_clk_inputs_valid;
  logic next_test_inputs_valid;
  logic next_outputs_settled;
  logic next_refresh_grant;
  logic next_vref_half_select;
  logic next_reset_required;
  logic drive;

  // The pin path bypasses all flip-flops so the part looks asynchronous to the tester.
  assign pins.addr = addr;
  assign pins.we_a14_n = we_a14_n;
  assign pins.cas_a15_n = cas_a15_n;
  assign pins.ras_a16_n = ras_a16_n;
  assign pins.ba = ba;
  assign pins.bg = bg;
  assign pins.act_n = act_n;
  assign pins.cke = cke;
  assign pins.odt = odt;
  assign pins.ck_t = ck_t;
  assign pins.ck_c = ck_c;
  assign pins.par = par;
  assign pins.alert_n = alert_n;
  assign pins.reset_n = reset_n;
  assign pins.test_enable_pin = test_enable_pin;
  assign pins.dm_lower_n = dm_lower_n;
  assign pins.dm_upper_n = dm_upper_n;
  assign pins.width_sel = width_sel;

  dct_minterm u_dct_minterm (
    .pins (pins)
  );

  // Enables come straight from the pins; a synchronised copy would lag by cycles.
  assign drive = test_enable_pin & ~cs_n;

  dct_outmap u_dct_outmap (
    .minterm (pins.minterm),
    .width_sel (width_sel),
    .drive (drive),
    .dq_value (dq_out),
    .dq_en (dq_oe),
    .dqs_value (dqs_out),
    .dqs_en (dqs_oe)
  );

  // Synchronisers: a level counts once the second and third stages agree.
  always_comb
  begin
    next_te_sync = {te_sync[1:0], test_enable_pin};
    next_cs_sync = {cs_sync[1:0], cs_n};
    next_te_stable = te_stable;
    next_cs_low_stable = cs_low_stable;
    if (te_sync[1] == te_sync[2])
      next_te_stable = te_sync[2];
    if (cs_sync[1] == cs_sync[2])
      next_cs_low_stable = ~cs_sync[2];
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      te_sync <= SYNC_RESET;
      cs_sync <= SYNC_RESET;
      te_stable <= 1'b0;
      cs_low_stable <= 1'b0;
    end
    else
    begin
      te_sync <= next_te_sync;
      cs_sync <= next_cs_sync;
      te_stable <= next_te_stable;
      cs_low_stable <= next_cs_low_stable;
    end
  end

  // Mode tracking, entry delays, refresh blocking and the exit flag.
  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    next_settle_cnt = settle_cnt;
    next_clk_inputs_valid = clk_inputs_valid;
    next_test_inputs_valid = test_inputs_valid;
    next_outputs_settled = outputs_settled;
    next_reset_required = reset_required;
    if (cnt != CNT_MAX)
      next_cnt = cnt + 8'h01;
    unique case (state)
      MODE_IDLE:
      begin
        next_clk_inputs_valid = 1'b0;
        next_test_inputs_valid = 1'b0;
        next_outputs_settled = 1'b0;
        next_cnt = CNT_RESET;
        next_settle_cnt = CNT_RESET;
        if (te_stable)
          next_state = MODE_ENTRY;
      end
      MODE_ENTRY:
      begin
        // Compared without adding one, so a saturated count cannot wrap and block entry.
        if (cnt >= CLK_CKE_CYC - 8'h01)
          next_clk_inputs_valid = 1'b1;
        // Sampling of the other inputs starts only once chip select permits it.
        if (cnt >= INPUT_EN_CYC - 8'h01 && cs_low_stable)
        begin
          next_state = MODE_ACTIVE;
          next_test_inputs_valid = 1'b1;
          next_settle_cnt = CNT_RESET;
        end
        if (!te_stable)
        begin
          next_state = MODE_IDLE;
          next_reset_required = 1'b1;
        end
      end
      MODE_ACTIVE:
      begin
        next_clk_inputs_valid = 1'b1;
        if (!cs_low_stable)
        begin
          next_settle_cnt = CNT_RESET;
          next_outputs_settled = 1'b0;
        end
        else if (settle_cnt + 8'h01 >= SETTLE_CYC)
        begin
          next_outputs_settled = 1'b1;
        end
        else
        begin
          next_settle_cnt = settle_cnt + 8'h01;
        end
        if (!te_stable)
        begin
          next_state = MODE_IDLE;
          next_reset_required = 1'b1;
        end
      end
    endcase
    // Refresh is held off from the first synchronised sight of test enable.
    next_refresh_grant = refresh_req & ~te_stable & (next_state == MODE_IDLE);
    next_vref_half_select = te_stable;
  end

  // Only a full reset clears the exit flag, since the array is then unknown.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      state <= MODE_IDLE;
      cnt <= CNT_RESET;
      settle_cnt <= CNT_RESET;
      clk_inputs_valid <= 1'b0;
      test_inputs_valid <= 1'b0;
      outputs_settled <= 1'b0;
      refresh_grant <= 1'b0;
      vref_half_select <= 1'b0;
      reset_required <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      settle_cnt <= next_settle_cnt;
      clk_inputs_valid <= next_clk_inputs_valid;
      test_inputs_valid <= next_test_inputs_valid;
      outputs_settled <= next_outputs_settled;
      refresh_grant <= next_refresh_grant;
      vref_half_select <= next_vref_half_select;
      reset_required <= next_reset_required;
    end
  end

  property p_mt0_x8;
    @(posedge ref_clk) disable iff (rst)
    (width_sel == WIDTH_X8) |-> dq_out[0] == (addr[1] ^ addr[6] ^ par);
  endproperty
  a_mt0_x8: assert property (p_mt0_x8) else $error("x8 bit 0 wrong");

  property p_mt9_x8;
    @(posedge ref_clk) disable iff (rst)
    (width_sel == WIDTH_X8) |-> dqs_out[1] == (bg[0] ^ addr[3] ^ (reset_n & test_enable_pin));
  endproperty
  a_mt9_x8: assert property (p_mt9_x8) else $error("x8 strobe c wrong");

  property p_mt7_x16;
    @(posedge ref_clk) disable iff (rst)
    (width_sel == WIDTH_X16) |-> dq_out[7] == (dm_upper_n ^ dm_lower_n ^ ck_t);
  endproperty
  a_mt7_x16: assert property (p_mt7_x16) else $error("x16 bit 7 wrong");

  property p_cs_hiz;
    @(posedge ref_clk) disable iff (rst)
    (cs_n || !test_enable_pin) |-> (dq_oe == 16'h0000 && dqs_oe == 4'h0);
  endproperty
  a_cs_hiz: assert property (p_cs_hiz) else $error("outputs driven while deselected");

  property p_x4_dq;
    @(posedge ref_clk) disable iff (rst)
    (width_sel == WIDTH_X4) |-> (dq_out[0] == (^{addr[1], addr[6], par, addr[8], alert_n, addr[9]})
      && dq_oe == (drive ? 16'h000F : 16'h0000));
  endproperty
  a_x4_dq: assert property (p_x4_dq) else $error("x4 data bit 0 wrong");

  property p_x4_dq3;
    @(posedge ref_clk) disable iff (rst)
    (width_sel == WIDTH_X4) |-> dq_out[3] == (act_n ^ addr[4] ^ ba[1] ^ bg[1] ^ ck_t);
  endproperty
  a_x4_dq3: assert property (p_x4_dq3) else $error("x4 data bit 3 wrong");

  property p_x4_dqs;
    @(posedge ref_clk) disable iff (rst)
    (width_sel == WIDTH_X4) |-> dqs_out[0] == (we_a14_n ^ addr[12] ^ ba[0]);
  endproperty
  a_x4_dqs: assert property (p_x4_dqs) else $error("x4 true strobe wrong");

  property p_x16_upper;
    @(posedge ref_clk) disable iff (rst)
    (width_sel == WIDTH_X16 && drive) |->
      (dq_out[15:8] == ~dq_out[7:0] && dqs_out[3:2] == ~dqs_out[1:0] && dqs_oe == 4'hF);
  endproperty
  a_x16_upper: assert property (p_x16_upper) else $error("x16 upper half wrong");

  property p_clk_entry;
    @(posedge ref_clk) disable iff (rst)
    $rose(te_stable) ##1 te_stable [*4] |-> ##[0:ENTRY_MAX] clk_inputs_valid;
  endproperty
  a_clk_entry: assert property (p_clk_entry) else $error("clock inputs not valid in time");

  property p_inputs_entry;
    @(posedge ref_clk) disable iff (rst)
    (state == MODE_ENTRY && te_stable && cs_low_stable && cnt >= INPUT_EN_CYC - 8'h01) |=>
      (state == MODE_ACTIVE && test_inputs_valid);
  endproperty
  a_inputs_entry: assert property (p_inputs_entry) else $error("test inputs never valid");

  property p_no_refresh;
    @(posedge ref_clk) disable iff (rst)
    te_stable |=> !refresh_grant;
  endproperty
  a_no_refresh: assert property (p_no_refresh) else $error("refresh granted in test mode");

  property p_exit_flag;
    @(posedge ref_clk) disable iff (rst)
    (state != MODE_IDLE && !te_stable) |=> (reset_required && state == MODE_IDLE);
  endproperty
  a_exit_flag: assert property (p_exit_flag) else $error("exit did not flag reset");

endmodule : dct_top

//--- rtl/dct_pkg.sv
/*
  Constants and types shared by the DRAM connectivity test logic.
  Assumes a single 10 MHz reference clock; the test path itself is clockless.
*/
package dct_pkg;

  localparam int CLK_PERIOD_NS = 100;

  // Width option of the part, given by a strap.
  localparam logic [1:0] WIDTH_X4 = 2'h0;
  localparam logic [1:0] WIDTH_X8 = 2'h1;
  localparam logic [1:0] WIDTH_X16 = 2'h2;

  // Entry and settle times in ns.
  localparam int CLK_CKE_TEST_INPUT_DELAY_NS = 200;
  localparam int TEST_INPUT_ENABLE_DELAY_NS = 500;
  localparam int TEST_OUTPUT_SETTLE_TIME_NS = 300;

  // Least times round up to whole cycles.
  localparam int CLK_CKE_CYC_I = (CLK_CKE_TEST_INPUT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int INPUT_EN_CYC_I = (TEST_INPUT_ENABLE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_CYC_I = (TEST_OUTPUT_SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] CLK_CKE_CYC = 8'(CLK_CKE_CYC_I);
  localparam logic [7:0] INPUT_EN_CYC = 8'(INPUT_EN_CYC_I);
  localparam logic [7:0] SETTLE_CYC = 8'(SETTLE_CYC_I);

  localparam logic [7:0] CNT_RESET = 8'h00;
  localparam logic [7:0] CNT_MAX = 8'hFF;
  localparam logic [2:0] SYNC_RESET = 3'h0;

  typedef enum logic [1:0] {MODE_IDLE, MODE_ENTRY, MODE_ACTIVE} dct_state_type;

endpackage : dct_pkg

//--- rtl/dct_pins_if.sv
/*
  Bundle of connectivity test inputs and the minterms formed from them.
  Assumes the top module drives the inputs straight from its pins.
*/
`timescale 1ns/10ps
interface dct_pins_if;
  logic [13:0] addr;
  logic we_a14_n;
  logic cas_a15_n;
  logic ras_a16_n;
  logic [1:0] ba;
  logic [1:0] bg;
  logic act_n;
  logic cke;
  logic odt;
  logic ck_t;
  logic ck_c;
  logic par;
  logic alert_n;
  logic reset_n;
  logic test_enable_pin;
  logic dm_lower_n;
  logic dm_upper_n;
  logic [1:0] width_sel;
  logic [9:0] minterm;

  modport src (
    output addr, we_a14_n, cas_a15_n, ras_a16_n, ba, bg, act_n, cke, odt,
    output ck_t, ck_c, par, alert_n, reset_n, test_enable_pin,
    output dm_lower_n, dm_upper_n, width_sel,
    input minterm
  );
  modport calc (
    input addr, we_a14_n, cas_a15_n, ras_a16_n, ba, bg, act_n, cke, odt,
    input ck_t, ck_c, par, alert_n, reset_n, test_enable_pin,
    input dm_lower_n, dm_upper_n, width_sel,
    output minterm
  );
endinterface : dct_pins_if

//--- rtl/dct_minterm.sv
/*
  Forms the ten connectivity test minterms from the test input pins.
  Assumes the inputs come straight from pins; nothing here is clocked.
*/
`timescale 1ns/10ps
module dct_minterm
  import dct_pkg::*;
(
  dct_pins_if.calc pins // Test inputs in, minterms out.
);

  logic term7;

  // The spare strap code behaves as the widest part, matching the output mapping.
  always_comb
  begin
    unique case (pins.width_sel)
      WIDTH_X4: term7 = pins.bg[1] ^ pins.ck_t;
      WIDTH_X8: term7 = pins.bg[1] ^ pins.dm_lower_n ^ pins.ck_t;
      default: term7 = pins.dm_upper_n ^ pins.dm_lower_n ^ pins.ck_t;
    endcase
  end

  assign pins.minterm[0] = pins.addr[1] ^ pins.addr[6] ^ pins.par;
  assign pins.minterm[1] = pins.addr[8] ^ pins.alert_n ^ pins.addr[9];
  assign pins.minterm[2] = pins.addr[2] ^ pins.addr[5] ^ pins.addr[13];
  assign pins.minterm[3] = pins.addr[0] ^ pins.addr[7] ^ pins.addr[11];
  assign pins.minterm[4] = pins.ck_c ^ pins.odt ^ pins.cas_a15_n;
  assign pins.minterm[5] = pins.cke ^ pins.ras_a16_n ^ pins.addr[10];
  assign pins.minterm[6] = pins.act_n ^ pins.addr[4] ^ pins.ba[1];
  assign pins.minterm[7] = term7;
  assign pins.minterm[8] = pins.we_a14_n ^ pins.addr[12] ^ pins.ba[0];
  assign pins.minterm[9] = pins.bg[0] ^ pins.addr[3]
                         ^ (pins.reset_n & pins.test_enable_pin);

endmodule : dct_minterm

//--- rtl/dct_outmap.sv
/*
  Maps the minterms onto data and strobe outputs for the x4, x8 or x16 part.
  Assumes enables are qualified by the caller with test enable and chip select.
*/
`timescale 1ns/10ps
module dct_outmap
  import dct_pkg::*;
(
  input wire logic [9:0] minterm, // Minterms from the test inputs.
  input wire logic [1:0] width_sel, // Part width strap.
  input wire logic drive, // Test mode active and chip selected.
  output logic [15:0] dq_value, // Data pin values.
  output logic [15:0] dq_en, // Data pin enables.
  output logic [3:0] dqs_value, // Strobes: lower t, lower c, upper t, upper c.
  output logic [3:0] dqs_en // Strobe enables.
);

  logic [7:0] low;

  always_comb
  begin
    low = minterm[7:0];
    dq_value = {~low, low};
    dqs_value = {~minterm[9], ~minterm[8], minterm[9], minterm[8]};
    dq_en = 16'h0000;
    dqs_en = 4'h0;
    unique case (width_sel)
      WIDTH_X4:
      begin
        dq_value[3:0] = {minterm[6] ^ minterm[7], minterm[4] ^ minterm[5],
                         minterm[2] ^ minterm[3], minterm[0] ^ minterm[1]};
        dq_en = drive ? 16'h000F : 16'h0000;
        dqs_en = drive ? 4'h3 : 4'h0;
      end
      WIDTH_X8:
      begin
        dq_en = drive ? 16'h00FF : 16'h0000;
        dqs_en = drive ? 4'h3 : 4'h0;
      end
      default:
      begin
        dq_en = drive ? 16'hFFFF : 16'h0000;
        dqs_en = drive ? 4'hF : 4'h0;
      end
    endcase
  end

endmodule : dct_outmap

//--- tb/dct_agent_model.sv
/*
  Behavioural board agent that drives the test input pins of the device.
  Assumes the bench supplies the wanted pattern and mode requests each cycle.
*/
`timescale 1ns/10ps
module dct_agent_model
(
  input wire logic ref_clk, // Bench clock.
  input wire logic [29:0] pat, // Pattern wanted on the test input pins.
  input wire logic want_test, // Bench asks for connectivity test.
  input wire logic want_cs, // Bench asks for the part to be selected.
  output logic [29:0] pins, // Address, command and control pins.
  output logic reset_n, // Device reset pin.
  output logic test_enable_pin, // Test enable pin.
  output logic cs_n // Chip select pin.
);
  int hi_cnt;
  int low_cnt;

  initial
  begin
    pins = 30'h0;
    reset_n = 1'b1;
    test_enable_pin = 1'b0;
    cs_n = 1'b1;
    hi_cnt = 0;
    low_cnt = 0;
  end

  // Pins move one step after the edge so the device never sees a race.
  always @(posedge ref_clk)
  begin
    #1;
    hi_cnt = reset_n ? hi_cnt + 1 : 0;
    if (low_cnt > 0)
    begin
      low_cnt--;
      reset_n = (low_cnt == 0);
    end
    if (want_test && !test_enable_pin && reset_n && hi_cnt > 2)
      test_enable_pin = 1'b1;
    else if (!want_test && test_enable_pin)
    begin
      // Leaving the mode leaves the part unknown, so a full reset follows.
      test_enable_pin = 1'b0;
      reset_n = 1'b0;
      low_cnt = 3;
    end
    cs_n = !(want_cs && test_enable_pin);
    // Clock enable is held high while deselected, in one assignment so no pin glitches.
    pins = cs_n ? (pat | 30'h00400000) : pat;
  end
endmodule : dct_agent_model

//--- tb/dram_connectivity_test_logic_bench.sv
/*
  Self-checking bench of the connectivity test logic: entry timing, random
  and corner patterns in every width, deselect, refresh block and exit.
  Assumes the agent model drives the test pins and the bench the straps.
*/
`timescale 1ns/10ps
module dram_connectivity_test_logic_bench;
  import dct_pkg::*;
  logic ref_clk, rst, want_test, want_cs, refresh_req;
  logic [29:0] pat, pins;
  logic [1:0] width_sel;
  logic reset_n, test_enable_pin, cs_n;
  logic [15:0] dq_out, dq_oe;
  logic [3:0] dqs_out, dqs_oe;
  logic clk_inputs_valid, test_inputs_valid, outputs_settled, refresh_grant;
  logic vref_half_select, reset_required;
  int n_fail, checked;

  dct_agent_model u_dct_agent_model (.ref_clk(ref_clk), .pat(pat), .want_test(want_test),
    .want_cs(want_cs), .pins(pins), .reset_n(reset_n), .test_enable_pin(test_enable_pin),
    .cs_n(cs_n));

  dct_top u_dct_top (.ref_clk(ref_clk), .rst(rst), .test_enable_pin(test_enable_pin),
    .cs_n(cs_n), .addr(pins[13:0]), .we_a14_n(pins[14]), .cas_a15_n(pins[15]),
    .ras_a16_n(pins[16]), .ba(pins[18:17]), .bg(pins[20:19]), .act_n(pins[21]),
    .cke(pins[22]), .odt(pins[23]), .ck_t(pins[24]), .ck_c(pins[25]), .par(pins[26]),
    .alert_n(pins[27]), .reset_n(reset_n), .dm_lower_n(pins[28]), .dm_upper_n(pins[29]),
    .width_sel(width_sel), .refresh_req(refresh_req), .dq_out(dq_out), .dq_oe(dq_oe),
    .dqs_out(dqs_out), .dqs_oe(dqs_oe), .clk_inputs_valid(clk_inputs_valid),
    .test_inputs_valid(test_inputs_valid), .outputs_settled(outputs_settled),
    .refresh_grant(refresh_grant), .vref_half_select(vref_half_select),
    .reset_required(reset_required));

  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  task step(input int k);
    repeat (k) @(posedge ref_clk);
    #2;
  endtask : step

  task give_verdict;
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // A wait that runs out ends the run, since later checks would only cascade.
  task wait_on(input int sel, input logic lvl, input int lim, output int n);
    logic v;
    n = 0;
    v = ~lvl;
    while (n < lim && v !== lvl)
    begin
      step(1);
      n++;
      case (sel)
        0: v = clk_inputs_valid;
        1: v = test_inputs_valid;
        2: v = outputs_settled;
        3: v = reset_required;
        default: v = test_enable_pin;
      endcase
    end
    if (v !== lvl)
    begin
      n_fail++;
      $display("BAD at %0t: wait %0d got %h expected %h", $time, sel, v, lvl);
      give_verdict();
    end
  endtask : wait_on

  function automatic logic [9:0] exp_mt();
    logic [13:0] a;
    logic m7;
    a = pins[13:0];
    m7 = pins[29] ^ pins[28] ^ pins[24];
    if (width_sel == WIDTH_X8)
      m7 = pins[20] ^ pins[28] ^ pins[24];
    if (width_sel == WIDTH_X4)
      m7 = pins[20] ^ pins[24];
    return {pins[19] ^ a[3] ^ (reset_n & test_enable_pin), pins[14] ^ a[12] ^ pins[17], m7,
      pins[21] ^ a[4] ^ pins[18], pins[22] ^ pins[16] ^ a[10], pins[25] ^ pins[23] ^ pins[15],
      a[0] ^ a[7] ^ a[11], a[2] ^ a[5] ^ a[13], a[8] ^ pins[27] ^ a[9], a[1] ^ a[6] ^ pins[26]};
  endfunction : exp_mt

  task chk_pins;
    logic [9:0] m;
    logic [15:0] e, oe;
    logic [3:0] so;
    m = exp_mt();
    e = {~m[7:0], m[7:0]};
    oe = 16'hFFFF;
    so = 4'hF;
    if (width_sel == WIDTH_X8)
    begin
      oe = 16'h00FF;
      so = 4'h3;
    end
    if (width_sel == WIDTH_X4)
    begin
      e[3:0] = {m[6] ^ m[7], m[4] ^ m[5], m[2] ^ m[3], m[0] ^ m[1]};
      oe = 16'h000F;
      so = 4'h3;
    end
    chk({16'h0000, dq_oe}, {16'h0000, oe});
    chk({16'h0000, dq_out & oe}, {16'h0000, e & oe});
    chk({28'h0, dqs_oe}, {28'h0, so});
    chk({28'h0, dqs_out & so}, {28'h0, {~m[9], ~m[8], m[9], m[8]} & so});
  endtask : chk_pins

  initial
  begin
    int n0;
    int n1;
    rst = 1'b1;
    want_test = 1'b0;
    want_cs = 1'b0;
    refresh_req = 1'b0;
    pat = 30'h0;
    width_sel = WIDTH_X4;
    n_fail = 0;
    checked = 0;
    void'($urandom(32'h5023782B));
    step(10);
    rst = 1'b0;
    chk({30'h0, reset_required, test_inputs_valid}, 32'h0);
    for (int w = 0; w < 4; w++)
    begin
      width_sel = 2'(w);
      pat = 30'($urandom);
      want_test = 1'b1;
      wait_on(4, 1'b1, 20, n0);
      wait_on(0, 1'b1, CLK_CKE_CYC_I + 6, n0);
      chk({16'h0, dq_oe}, 32'h0);
      want_cs = 1'b1;
      wait_on(1, 1'b1, INPUT_EN_CYC_I + 10, n1);
      chk({31'h0, (n0 + n1 >= INPUT_EN_CYC_I)}, 32'h1);
      chk({31'h0, vref_half_select}, 32'h1);
      refresh_req = 1'b1;
      step(2);
      chk({31'h0, refresh_grant}, 32'h0);
      wait_on(2, 1'b1, SETTLE_CYC_I + 6, n0);
      for (int i = 0; i < 10; i++)
      begin
        pat = (i == 0) ? 30'h0 : (i == 1) ? 30'h3FFFFFFF : 30'($urandom);
        step(2);
        chk_pins();
      end
      want_cs = 1'b0;
      step(2);
      chk({dq_oe, 12'h0, dqs_oe}, 32'h0);
      wait_on(2, 1'b0, 6, n0);
      want_cs = 1'b1;
      pat = 30'($urandom);
      step(2);
      chk_pins();
      want_test = 1'b0;
      wait_on(3, 1'b1, 8, n0);
      step(2);
      chk({16'h0, dq_oe}, 32'h0);
      chk({30'h0, refresh_grant, vref_half_select}, 32'h2);
      refresh_req = 1'b0;
      want_cs = 1'b0;
      rst = 1'b1;
      step(2);
      rst = 1'b0;
      chk({31'h0, reset_required}, 32'h0);
    end
    give_verdict();
  end
endmodule : dram_connectivity_test_logic_bench
